/* inc/brcr_defines.vh */
`ifndef BRCR_DEFINES_VH
`define BRCR_DEFINES_VH

// ****************************************************************
// register offsets
// ****************************************************************
`define BRCR_ADDR_BOOST_CFG 8'h11
`define BRCR_ADDR_DUTY_LOW 8'h12
`define BRCR_ADDR_DUTY_HIGH 8'h13
`define BRCR_ADDR_SINK_RAMP 8'h14
`define BRCR_ADDR_FS_RAMP 8'h15

// ****************************************************************
// reset values
// ****************************************************************
`define BRCR_RST_BOOST_CFG 8'h35
`define BRCR_RST_SINK_RAMP 8'h44
`define BRCR_RST_FS_RAMP 8'hf8

// ****************************************************************
// field positions
// ****************************************************************
`define BRCR_INDUCTOR_HI 7
`define BRCR_INDUCTOR_LO 6
`define BRCR_CURCAP_HI 1
`define BRCR_CURCAP_LO 0
`define BRCR_ON_RAMP_HI 7
`define BRCR_ON_RAMP_LO 4
`define BRCR_OFF_RAMP_HI 3
`define BRCR_OFF_RAMP_LO 0
`define BRCR_FS_CODE_HI 7
`define BRCR_FS_CODE_LO 3
`define BRCR_DUTY_RAMP_HI 2
`define BRCR_DUTY_RAMP_LO 0
`define BRCR_DUTY_W 11

// ****************************************************************
// decoded values
// ****************************************************************
`define BRCR_L_4U7_NH 14'd4700
`define BRCR_L_10U_NH 14'd10000
`define BRCR_L_15U_NH 14'd15000
`define BRCR_CURCAP_BASE_MA 12'd1200
`define BRCR_CURCAP_STEP_MA 12'd300
`define BRCR_FS_BASE_UA 15'd5200
`define BRCR_FS_STEP_UA 15'd800

// ****************************************************************
// timing
// ****************************************************************
`define BRCR_CLK_MHZ 25
`define BRCR_SINK_BASE_US 512
`define BRCR_DUTY_BASE_US 2000
`define BRCR_SINK_BASE_CYCLES (`BRCR_SINK_BASE_US * `BRCR_CLK_MHZ)
`define BRCR_DUTY_BASE_CYCLES (`BRCR_DUTY_BASE_US * `BRCR_CLK_MHZ)

`endif

/* hdl/brcr_ramp.v */
`timescale 1ns/1ps
`include "brcr_defines.vh"

// ****************************************************************
// linear ramp: a full swing of the level takes span clock cycles
// ****************************************************************
module brcr_ramp #(
    parameter LW = 11
) (
    input wire clk,
    input wire rst_n,
    input wire clear,
    input wire [31:0] span,
    input wire [LW-1:0] target,
    output reg [LW-1:0] level,
    output wire busy
);
    // one full swing is 2^LW-1 steps; the phase gains that much per
    // cycle, so a partial swing takes its share of span
    localparam [31:0] STEP = (32'd1 << LW) - 32'd1;

    reg [31:0] phase;
    wire [32:0] next_phase = {1'b0, phase} + {1'b0, STEP};

    assign busy = (level != target);

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase <= 32'h0000_0000;
            level <= {LW{1'b0}};
        end else if (clear) begin
            phase <= 32'h0000_0000;
            level <= {LW{1'b0}};
        end else if (level == target) begin
            phase <= 32'h0000_0000;
        end else if (next_phase >= {1'b0, span}) begin
            phase <= next_phase[31:0] - span; // [R11]
            if (level < target) begin
                level <= level + {{(LW-1){1'b0}}, 1'b1};
            end else begin
                level <= level - {{(LW-1){1'b0}}, 1'b1};
            end
        end else begin
            phase <= next_phase[31:0];
        end
    end
endmodule

/* hdl/brcr_duty_snap.v */
`timescale 1ns/1ps
`include "brcr_defines.vh"

// ****************************************************************
// duty code read-out with a held upper part
// ****************************************************************
module brcr_duty_snap (
    input wire clk,
    input wire rst_n,
    input wire [10:0] measured_duty_code,
    input wire low_read,
    input wire other_access,
    output wire [7:0] low_byte,
    output wire [7:0] high_byte
);
    // a low-byte read freezes the upper bits until the next access,
    // so a back-to-back pair always comes from one sample
    reg hold;
    reg [2:0] high_bits;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hold <= 1'b0;
            high_bits <= 3'b000;
        end else if (low_read) begin
            hold <= 1'b1;
            high_bits <= measured_duty_code[10:8];
        end else if (other_access) begin
            hold <= 1'b0;
            high_bits <= measured_duty_code[10:8];
        end else if (!hold) begin
            high_bits <= measured_duty_code[10:8];
        end
    end

    assign low_byte = measured_duty_code[7:0]; // [R4]
    assign high_byte = {5'b00000, high_bits}; // [R5]
endmodule

/* hdl/brcr_regs.v */
`timescale 1ns/1ps
`include "brcr_defines.vh"

// Behaviour
// R1: all sinks disabled stops boost switching
// R2: inductor field: 4.7, 10, 15 uH
// R3: current cap field: 1.2 to 2.1 A
// R4: low duty byte is code bits 7:0
// R5: high duty register bits 2:0, rest zero
// R6: host reads both duty bytes back-to-back
// R7: on ramp 512 us doubling, reset 8 ms
// R8: off ramp same encoding, reset code 0100
// R9: full scale 5.2 mA plus 0.8 per code
// R10: duty ramp 2 ms doubling to 256 ms
// R11: duty ramp time scales with change
// R12: soft reset restores control register defaults
// R13: writes to duty code registers ignored
module brcr_regs #(
    parameter SINK_BASE_CYCLES = `BRCR_SINK_BASE_CYCLES,
    parameter DUTY_BASE_CYCLES = `BRCR_DUTY_BASE_CYCLES
) (
    input wire clk,
    input wire rst_n,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    output reg reg_hit,
    input wire soft_reset,
    input wire [3:0] current_sink_enables,
    input wire [10:0] measured_duty_code,
    output reg boost_switch_en,
    output reg [1:0] boost_inductor_choice,
    output reg [13:0] boost_inductor_nh,
    output reg [1:0] boost_switch_current_cap,
    output reg [11:0] boost_switch_current_cap_ma,
    output reg [4:0] full_scale_sink_code,
    output reg [14:0] full_scale_led_current,
    output wire [10:0] sink_ramp_level,
    output wire [10:0] duty_ramp_level,
    output reg [1:0] sink_state
);
    // ****************************************************************
    // sink ramp states
    // ****************************************************************
    localparam [1:0] ST_OFF = 2'b00;
    localparam [1:0] ST_RAMP_ON = 2'b01;
    localparam [1:0] ST_ON = 2'b10;
    localparam [1:0] ST_RAMP_OFF = 2'b11;

    localparam [31:0] SINK_BASE = SINK_BASE_CYCLES;
    localparam [31:0] DUTY_BASE = DUTY_BASE_CYCLES;

    // ****************************************************************
    // control registers
    // ****************************************************************
    reg [7:0] boost_inductor_current_cfg;
    reg [7:0] sink_on_off_ramp_cfg;
    reg [7:0] full_scale_and_duty_ramp_cfg;

    wire hit_boost = (reg_addr == `BRCR_ADDR_BOOST_CFG);
    wire hit_low = (reg_addr == `BRCR_ADDR_DUTY_LOW);
    wire hit_high = (reg_addr == `BRCR_ADDR_DUTY_HIGH);
    wire hit_sink = (reg_addr == `BRCR_ADDR_SINK_RAMP);
    wire hit_fs = (reg_addr == `BRCR_ADDR_FS_RAMP);
    wire hit_any = hit_boost | hit_low | hit_high | hit_sink | hit_fs;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            boost_inductor_current_cfg <= `BRCR_RST_BOOST_CFG;
            sink_on_off_ramp_cfg <= `BRCR_RST_SINK_RAMP;
            full_scale_and_duty_ramp_cfg <= `BRCR_RST_FS_RAMP;
        end else if (soft_reset) begin
            // soft reset outranks a write in the same cycle
            boost_inductor_current_cfg <= `BRCR_RST_BOOST_CFG; // [R12]
            sink_on_off_ramp_cfg <= `BRCR_RST_SINK_RAMP; // [R12]
            full_scale_and_duty_ramp_cfg <= `BRCR_RST_FS_RAMP; // [R12]
        end else if (reg_wr) begin
            // duty code offsets have no storage behind them
            if (hit_boost) begin // [R13]
                boost_inductor_current_cfg <= reg_wdata;
            end
            if (hit_sink) begin
                sink_on_off_ramp_cfg <= reg_wdata;
            end
            if (hit_fs) begin
                full_scale_and_duty_ramp_cfg <= reg_wdata;
            end
        end
    end

    // ****************************************************************
    // duty code read-out
    // ****************************************************************
    wire [7:0] duty_low_byte;
    wire [7:0] duty_high_byte;
    wire low_read = reg_rd & hit_low;
    wire other_access = (reg_rd | reg_wr) & ~low_read;

    // pairing of the two reads relies on the host reading them in turn
    brcr_duty_snap u_snap ( // [R6]
        .clk(clk),
        .rst_n(rst_n),
        .measured_duty_code(measured_duty_code),
        .low_read(low_read),
        .other_access(other_access),
        .low_byte(duty_low_byte),
        .high_byte(duty_high_byte)
    );

    // ****************************************************************
    // read path
    // ****************************************************************
    reg [7:0] next_rdata;

    always @* begin
        next_rdata = 8'h00;
        if (hit_boost) begin
            next_rdata = boost_inductor_current_cfg;
        end else if (hit_low) begin
            next_rdata = duty_low_byte; // [R4]
        end else if (hit_high) begin
            next_rdata = duty_high_byte; // [R5]
        end else if (hit_sink) begin
            next_rdata = sink_on_off_ramp_cfg;
        end else if (hit_fs) begin
            next_rdata = full_scale_and_duty_ramp_cfg;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
            reg_hit <= 1'b0;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
            reg_hit <= hit_any;
        end else begin
            reg_hit <= 1'b0;
        end
    end

    // ****************************************************************
    // decoded settings
    // ****************************************************************
    wire [1:0] ind_field = boost_inductor_current_cfg[
        `BRCR_INDUCTOR_HI:`BRCR_INDUCTOR_LO];
    wire [1:0] cap_field = boost_inductor_current_cfg[
        `BRCR_CURCAP_HI:`BRCR_CURCAP_LO];
    wire [4:0] fs_field = full_scale_and_duty_ramp_cfg[
        `BRCR_FS_CODE_HI:`BRCR_FS_CODE_LO];
    wire [3:0] on_code = sink_on_off_ramp_cfg[
        `BRCR_ON_RAMP_HI:`BRCR_ON_RAMP_LO];
    wire [3:0] off_code = sink_on_off_ramp_cfg[
        `BRCR_OFF_RAMP_HI:`BRCR_OFF_RAMP_LO];
    wire [2:0] duty_code = full_scale_and_duty_ramp_cfg[
        `BRCR_DUTY_RAMP_HI:`BRCR_DUTY_RAMP_LO];

    wire [23:0] cap_prod = {12'h000, `BRCR_CURCAP_STEP_MA} *
        {22'h00_0000, cap_field};
    wire [29:0] fs_prod = {15'h0000, `BRCR_FS_STEP_UA} *
        {25'h000_0000, fs_field};

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            boost_inductor_choice <= 2'b00;
            boost_inductor_nh <= `BRCR_L_4U7_NH;
            boost_switch_current_cap <= 2'b01;
            boost_switch_current_cap_ma <= 12'h000;
            full_scale_sink_code <= 5'b11111;
            full_scale_led_current <= 15'h0000;
        end else begin
            case (ind_field) // [R2]
                2'b00: begin
                    boost_inductor_choice <= 2'b00;
                    boost_inductor_nh <= `BRCR_L_4U7_NH;
                end
                2'b01: begin
                    boost_inductor_choice <= 2'b01;
                    boost_inductor_nh <= `BRCR_L_10U_NH;
                end
                default: begin
                    // both upper codes select the largest inductor
                    boost_inductor_choice <= 2'b10;
                    boost_inductor_nh <= `BRCR_L_15U_NH;
                end
            endcase
            boost_switch_current_cap <= cap_field; // [R3]
            boost_switch_current_cap_ma <= `BRCR_CURCAP_BASE_MA +
                cap_prod[11:0]; // [R3]
            full_scale_sink_code <= fs_field; // [R9]
            full_scale_led_current <= `BRCR_FS_BASE_UA +
                fs_prod[14:0]; // [R9]
        end
    end

    // ****************************************************************
    // ramp spans in clock cycles
    // ****************************************************************
    // the longest sink ramp is 2^15 base periods, which fits 32 bits
    // only while the base stays below 2^17 cycles
    wire [31:0] on_span = SINK_BASE << on_code; // [R7]
    wire [31:0] off_span = SINK_BASE << off_code; // [R8]
    wire [31:0] duty_span = DUTY_BASE << duty_code; // [R10]

    // ****************************************************************
    // boost gating and sink ramp sequencing
    // ****************************************************************
    wire any_sink = |current_sink_enables;
    wire sink_busy;
    wire [10:0] sink_target = any_sink ? 11'h7ff : 11'h000;
    wire [31:0] sink_span = any_sink ? on_span : off_span;
    reg [1:0] next_state;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            boost_switch_en <= 1'b0;
        end else begin
            boost_switch_en <= any_sink; // [R1]
        end
    end

    always @* begin
        next_state = sink_state;
        case (sink_state)
            ST_OFF: begin
                if (any_sink) begin
                    next_state = ST_RAMP_ON;
                end
            end
            ST_RAMP_ON: begin
                if (!any_sink) begin
                    next_state = ST_RAMP_OFF;
                end else if (!sink_busy) begin
                    next_state = ST_ON;
                end
            end
            ST_ON: begin
                if (!any_sink) begin
                    next_state = ST_RAMP_OFF;
                end
            end
            ST_RAMP_OFF: begin
                if (any_sink) begin
                    next_state = ST_RAMP_ON;
                end else if (!sink_busy) begin
                    next_state = ST_OFF;
                end
            end
            default: begin
                next_state = ST_OFF;
            end
        endcase
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sink_state <= ST_OFF;
        end else if (soft_reset) begin
            sink_state <= ST_OFF;
        end else begin
            sink_state <= next_state;
        end
    end

    // ****************************************************************
    // ramps
    // ****************************************************************
    brcr_ramp #(
        .LW(`BRCR_DUTY_W)
    ) u_sink_ramp ( // [R7] [R8]
        .clk(clk),
        .rst_n(rst_n),
        .clear(soft_reset),
        .span(sink_span),
        .target(sink_target),
        .level(sink_ramp_level),
        .busy(sink_busy)
    );

    brcr_ramp #(
        .LW(`BRCR_DUTY_W)
    ) u_duty_ramp ( // [R10] [R11]
        .clk(clk),
        .rst_n(rst_n),
        .clear(soft_reset),
        .span(duty_span),
        .target(measured_duty_code),
        .level(duty_ramp_level),
        .busy()
    );
endmodule

/* bench/brcr_regs_asserts.sv */
`timescale 1ns/1ps
// ****************************************************************
// port checker for the backlight ramp register bank
// ****************************************************************
module brcr_regs_asserts #(
    parameter SINK_BASE_CYCLES = 12800,
    parameter DUTY_BASE_CYCLES = 50000
) (
    input wire clk,
    input wire rst_n,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata,
    input wire reg_hit,
    input wire soft_reset,
    input wire [3:0] current_sink_enables,
    input wire [10:0] measured_duty_code,
    input wire boost_switch_en,
    input wire [1:0] boost_inductor_choice,
    input wire [13:0] boost_inductor_nh,
    input wire [1:0] boost_switch_current_cap,
    input wire [11:0] boost_switch_current_cap_ma,
    input wire [4:0] full_scale_sink_code,
    input wire [14:0] full_scale_led_current,
    input wire [10:0] sink_ramp_level,
    input wire [10:0] duty_ramp_level,
    input wire [1:0] sink_state
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // decoded outputs settle one edge after release, so skip that edge
    chk_boost_follows_en: assert property (1 |=> boost_switch_en ==
        |$past(current_sink_enables)) else $error("boost enable wrong");
    chk_inductor_nh_map: assert property ($past(rst_n) |->
        boost_inductor_choice != 2'h3 && boost_inductor_nh ==
        (boost_inductor_choice == 2'h0 ? 14'h125c :
        boost_inductor_choice == 2'h1 ? 14'h2710 : 14'h3a98))
        else $error("inductor decode wrong");
    chk_cap_ma_map: assert property ($past(rst_n) &&
        $stable(boost_switch_current_cap) |-> boost_switch_current_cap_ma
        == 12'h4b0 + 12'h12c * {10'h000, boost_switch_current_cap})
        else $error("current cap decode wrong");
    // the register takes the write at one edge, the decode at the next
    chk_cap_written: assert property (reg_wr && !soft_reset &&
        reg_addr == 8'h11 |=> ##1 boost_switch_current_cap ==
        $past(reg_wdata[1:0], 2)) else $error("current cap not written");
    chk_low_byte_read: assert property (reg_rd && reg_addr == 8'h12
        |=> reg_rdata == $past(measured_duty_code[7:0]) && reg_hit)
        else $error("duty low byte wrong");
    chk_led_current_map: assert property ($past(rst_n) &&
        $stable(full_scale_sink_code) |-> full_scale_led_current ==
        15'h1450 + 15'h0320 * {10'h000, full_scale_sink_code})
        else $error("full scale current wrong");
    chk_soft_defaults: assert property (soft_reset |=> ##1
        full_scale_sink_code == 5'h1f && boost_switch_current_cap == 2'h1
        && boost_inductor_choice == 2'h0) else $error("soft reset missed");
    chk_unmapped_zero: assert property (reg_rd && (reg_addr < 8'h11 ||
        reg_addr > 8'h15) |=> reg_rdata == 8'h00 && !reg_hit)
        else $error("unmapped read not empty");
    // soft reset drops the ramp to zero in one step
    chk_duty_slew_one: assert property (!soft_reset |=>
        duty_ramp_level - $past(duty_ramp_level) + 11'h001 <= 11'h002)
        else $error("duty ramp jumped");
    cover property (sink_state == 2'h2);
    cover property (reg_hit && reg_rdata == 8'hf8);
    cover property (soft_reset);
endmodule

bind brcr_regs brcr_regs_asserts #(.SINK_BASE_CYCLES(SINK_BASE_CYCLES),
    .DUTY_BASE_CYCLES(DUTY_BASE_CYCLES)) i_brcr_regs_asserts (.clk(clk),
    .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_hit(reg_hit), .soft_reset(soft_reset),
    .current_sink_enables(current_sink_enables),
    .measured_duty_code(measured_duty_code),
    .boost_switch_en(boost_switch_en),
    .boost_inductor_choice(boost_inductor_choice),
    .boost_inductor_nh(boost_inductor_nh),
    .boost_switch_current_cap(boost_switch_current_cap),
    .boost_switch_current_cap_ma(boost_switch_current_cap_ma),
    .full_scale_sink_code(full_scale_sink_code),
    .full_scale_led_current(full_scale_led_current),
    .sink_ramp_level(sink_ramp_level), .duty_ramp_level(duty_ramp_level),
    .sink_state(sink_state));

/* bench/brcr_regs_tb_top.sv */
`timescale 1ns/1ps
module brcr_regs_tb_top;
    // short base spans keep the ramps to a few thousand cycles
    localparam int BASE = 2048;
    logic clk, rst_n, reg_wr, reg_rd, reg_hit, soft_reset, boost_switch_en;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [3:0] current_sink_enables;
    logic [10:0] measured_duty_code, sink_ramp_level, duty_ramp_level;
    logic [1:0] boost_inductor_choice, boost_switch_current_cap, sink_state;
    logic [13:0] boost_inductor_nh;
    logic [11:0] boost_switch_current_cap_ma;
    logic [4:0] full_scale_sink_code;
    logic [14:0] full_scale_led_current;
    int failures, checks_done, i;
    logic [15:0] nh_tab [4] = '{16'h125c, 16'h2710, 16'h3a98, 16'h3a98};
    logic [4:0] fs_tab [4] = '{5'h00, 5'h01, 5'h13, 5'h1f};

    brcr_regs #(.SINK_BASE_CYCLES(BASE), .DUTY_BASE_CYCLES(BASE)) i_brcr_regs (
        .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .reg_hit(reg_hit), .soft_reset(soft_reset),
        .current_sink_enables(current_sink_enables),
        .measured_duty_code(measured_duty_code),
        .boost_switch_en(boost_switch_en),
        .boost_inductor_choice(boost_inductor_choice),
        .boost_inductor_nh(boost_inductor_nh),
        .boost_switch_current_cap(boost_switch_current_cap),
        .boost_switch_current_cap_ma(boost_switch_current_cap_ma),
        .full_scale_sink_code(full_scale_sink_code),
        .full_scale_led_current(full_scale_led_current),
        .sink_ramp_level(sink_ramp_level), .duty_ramp_level(duty_ramp_level),
        .sink_state(sink_state));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask

    task summarize;
        $display("checks %0d, mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1 reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge clk);
        #1 reg_wr = 1'b0;
    endtask

    task rd(input logic [7:0] a, input logic [7:0] exp, input logic hit);
        @(posedge clk);
        #1 reg_addr = a;
        reg_rd = 1'b1;
        @(posedge clk);
        #1 reg_rd = 1'b0;
        check(16'(reg_rdata), 16'(exp));
        check(16'(reg_hit), 16'(hit));
    endtask

    // time a ramp to its target; the tolerance covers sampling slack
    task ramp(input bit duty, input logic [10:0] tgt, input int exp);
        int n;
        n = 0;
        while ((duty ? duty_ramp_level : sink_ramp_level) !== tgt &&
            n < exp + exp / 32 + 64) begin
            @(posedge clk);
            #1 n++;
        end
        check(16'(n >= exp - exp / 64 - 4 && n <= exp + exp / 64 + 4), 16'h1);
        if (n >= exp + exp / 32 + 64) begin
            failures++;
            summarize;
        end
    endtask

    task tick2;
        repeat (2) @(posedge clk);
        #1;
    endtask

    initial begin
        repeat (100000) @(posedge clk);
        failures++;
        summarize;
    end

    initial begin
        failures = 0;
        checks_done = 0;
        {rst_n, reg_wr, reg_rd, soft_reset} = 4'h0;
        {reg_addr, reg_wdata, current_sink_enables} = 20'h0_0000;
        measured_duty_code = 11'h000;
        repeat (6) @(posedge clk);
        #1 rst_n = 1'b1;
        rd(8'h11, 8'h35, 1'b1);
        rd(8'h14, 8'h44, 1'b1);
        rd(8'h15, 8'hf8, 1'b1);
        check(16'(boost_switch_current_cap_ma), 16'h05dc);
        check(16'(full_scale_led_current), 16'h7530);
        $display("test reset_values done");
        for (i = 0; i < 4; i++) begin
            wr(8'h11, {i[1:0], 4'hd, i[1:0]});
            wr(8'h15, {fs_tab[i], 3'h0});
            rd(8'h11, {i[1:0], 4'hd, i[1:0]}, 1'b1);
            check(16'(boost_inductor_nh), nh_tab[i]);
            check(16'(boost_inductor_choice), 16'(i == 3 ? 2 : i));
            check(16'(boost_switch_current_cap_ma), 16'(1200 + 300 * i));
            check(16'(full_scale_led_current), 16'(5200 + 800 * fs_tab[i]));
        end
        $display("test field_decode done");
        for (i = 0; i < 4; i++) begin
            current_sink_enables = 4'h1 << i;
            tick2;
            check(16'(boost_switch_en), 16'h1);
            current_sink_enables = 4'h0;
            tick2;
            check(16'(boost_switch_en), 16'h0);
        end
        $display("test boost_gate done");
        wr(8'h14, 8'h01);
        current_sink_enables = 4'h8;
        ramp(1'b0, 11'h7ff, BASE);
        tick2;
        check(16'(sink_state), 16'h2);
        current_sink_enables = 4'h0;
        ramp(1'b0, 11'h000, 2 * BASE);
        $display("test sink_ramp done");
        wr(8'h15, 8'hf8);
        measured_duty_code = 11'h400;
        ramp(1'b1, 11'h400, BASE / 2);
        wr(8'h15, 8'hf9);
        measured_duty_code = 11'h000;
        ramp(1'b1, 11'h000, BASE);
        $display("test duty_ramp done");
        measured_duty_code = 11'h5a3;
        tick2;
        rd(8'h12, 8'ha3, 1'b1);
        measured_duty_code = 11'h7ff;
        rd(8'h13, 8'h05, 1'b1);
        rd(8'h13, 8'h07, 1'b1);
        wr(8'h12, 8'h55);
        wr(8'h13, 8'h00);
        rd(8'h12, 8'hff, 1'b1);
        rd(8'h20, 8'h00, 1'b0);
        $display("test duty_readout done");
        wr(8'h11, 8'h00);
        @(posedge clk);
        #1 soft_reset = 1'b1;
        @(posedge clk);
        #1 soft_reset = 1'b0;
        rd(8'h11, 8'h35, 1'b1);
        rd(8'h14, 8'h44, 1'b1);
        rd(8'h15, 8'hf8, 1'b1);
        check(16'(boost_switch_current_cap_ma), 16'h05dc);
        $display("test soft_reset done");
        summarize;
    end
endmodule
